// ---- cl_pkg.sv ----
// Constants, register map and helpers for the closed-loop scaling and load-angle block.
// Assumes one 100 MHz system clock and a word-aligned Avalon-MM register bus.
//
// Overview of operation
// - Closed-loop enable overrides every open-loop scale option
// - Target: minimum, linear ramp, maximum above limit
// - Raise applied scale one step per up-delay
// - Zero up-delay applies higher target at once
// - Lower applied scale one step per down-delay
// - Zero down-delay applies lower target at once
// - Add compensation angle to commutation in motion direction
// - Angle zero, linear ramp, then maximum with velocity
// - Maximum compensation angle resets to 255 (90 degrees)
// - Read-only measured encoder velocity register
// - Read-only filtered encoder velocity register
// - Filter wait field sets cycles between samples
// - Absolute encoder uses serial request period instead
// - Filter: mean minus mean shifted plus sample shifted
package cl_pkg;

   localparam int unsigned ADDR_W   = 9;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned BE_W     = 4;
   localparam int unsigned IDX_W    = 7;
   localparam int unsigned SCALE_W  = 8;
   localparam int unsigned ANGLE_W  = 10;
   localparam int unsigned LIMIT_W  = 9;
   localparam int unsigned INTERP_W = 33;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CURRENT_CONTROL = 7'h05;
   localparam logic [IDX_W-1:0] IDX_CURRENT_LIMITS  = 7'h06;
   localparam logic [IDX_W-1:0] IDX_ENCODER_INPUT   = 7'h07;
   localparam logic [IDX_W-1:0] IDX_UP_DELAY        = 7'h18;
   localparam logic [IDX_W-1:0] IDX_DOWN_DELAY      = 7'h19;
   localparam logic [IDX_W-1:0] IDX_MAX_ANGLE       = 7'h1C;
   localparam logic [IDX_W-1:0] IDX_DEVIATION_LIMIT = 7'h1D;
   localparam logic [IDX_W-1:0] IDX_MIN_VELOCITY    = 7'h60;
   localparam logic [IDX_W-1:0] IDX_VELOCITY_SPAN   = 7'h61;
   localparam logic [IDX_W-1:0] IDX_FILTER_CONFIG   = 7'h63;
   localparam logic [IDX_W-1:0] IDX_MEASURED_VEL    = 7'h65;
   localparam logic [IDX_W-1:0] IDX_FILTERED_VEL    = 7'h66;

   // Field positions
   localparam int unsigned CC_CL_SCALE_EN = 0;
   localparam int unsigned ENC_ABSOLUTE   = 0;
   localparam int unsigned ENC_EMF_EN     = 1;
   localparam int unsigned LIM_MIN_LSB    = 0;
   localparam int unsigned LIM_MAX_LSB    = 8;
   localparam int unsigned LIM_START_LSB  = 16;
   localparam int unsigned FLT_WAIT_LSB   = 0;
   localparam int unsigned FLT_WAIT_W     = 8;
   localparam int unsigned FLT_EXP_LSB    = 8;
   localparam int unsigned FLT_EXP_W      = 4;

   // Reset values
   localparam logic [DATA_W-1:0]  REG_RST       = 32'h0000_0000;
   localparam logic [SCALE_W-1:0] MAX_ANGLE_RST = 8'hFF;

   typedef enum logic [2:0] {
      RAMP_HOLD = 3'b001,
      RAMP_UP   = 3'b010,
      RAMP_DOWN = 3'b100
   } ramp_state_t;

   function automatic logic [DATA_W-1:0] abs_val(input logic signed [DATA_W-1:0] v);
      abs_val = v[DATA_W-1] ? DATA_W'(-v) : DATA_W'(v);
   endfunction

   function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                  input logic [DATA_W-1:0] new_v,
                                                  input logic [BE_W-1:0]   be);
      be_merge = old_v;
      for (int i = 0; i < BE_W; i++) begin
         if (be[i]) begin
            be_merge[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
   endfunction

endpackage

// ---- closed_loop_current_and_load_angle.sv ----
// Closed-loop current scaling, scale ramping, encoder velocity filter and
// back-EMF load-angle compensation, with an Avalon-MM register slave.
// Assumes encoder inputs and commutation angle come from logic on clk.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
module closed_loop_current_and_load_angle (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // Avalon-MM slave
   input  wire logic [cl_pkg::ADDR_W-1:0]    address,
   input  wire logic                         read,
   input  wire logic                         write,
   input  wire logic [cl_pkg::BE_W-1:0]      byteenable,
   input  wire logic [cl_pkg::DATA_W-1:0]    writedata,
   output logic      [cl_pkg::DATA_W-1:0]    readdata,
   output logic                              waitrequest,
   // Encoder unit
   input  wire logic signed [cl_pkg::DATA_W-1:0] position_deviation,
   input  wire logic signed [cl_pkg::DATA_W-1:0] measured_encoder_velocity,
   input  wire logic [cl_pkg::DATA_W-1:0]    serial_request_period,
   // Open-loop scaling path
   input  wire logic [cl_pkg::SCALE_W-1:0]   open_loop_scale,
   // Commutation path and applied scale
   input  wire logic [cl_pkg::ANGLE_W-1:0]   commutation_angle,
   output logic      [cl_pkg::ANGLE_W-1:0]   commutation_out,
   output logic      [cl_pkg::SCALE_W-1:0]   applied_scale,
   output logic      [cl_pkg::SCALE_W-1:0]   comp_angle
);
   import cl_pkg::*;

   // Register file
   logic [DATA_W-1:0]  current_control_q;
   logic [DATA_W-1:0]  closed_loop_current_limits_q;
   logic [DATA_W-1:0]  encoder_input_settings_q;
   logic [DATA_W-1:0]  scale_up_step_delay_q;
   logic [DATA_W-1:0]  scale_down_step_delay_q;
   logic [SCALE_W-1:0] max_compensation_angle_q;
   logic [LIMIT_W-1:0] full_scale_deviation_limit_q;
   logic [DATA_W-1:0]  compensation_min_velocity_q;
   logic [DATA_W-1:0]  compensation_velocity_span_q;
   logic [DATA_W-1:0]  velocity_filter_config_q;

   // Bus handshake
   logic               waitrequest_q;
   logic [DATA_W-1:0]  readdata_q;
   logic [DATA_W-1:0]  read_val;
   logic [IDX_W-1:0]   reg_idx;
   logic               aligned;
   logic               wr_commit;

   // Scaling
   logic [DATA_W-1:0]  dev_abs;
   logic [SCALE_W-1:0] cl_target;
   logic [SCALE_W-1:0] target_scale;
   logic [SCALE_W-1:0] applied_scale_q;
   logic [DATA_W-1:0]  step_cnt_q;
   logic [DATA_W-1:0]  step_cnt_inc;
   logic [DATA_W-1:0]  sel_delay;
   ramp_state_t        ramp_state_q;
   ramp_state_t        ramp_state_d;
   logic               cl_en;

   // Velocity filter
   logic signed [DATA_W-1:0] filtered_encoder_velocity_q;
   logic [DATA_W-1:0]  wait_cnt_q;
   logic [DATA_W-1:0]  wait_cnt_inc;
   logic [DATA_W-1:0]  sample_period;
   logic [FLT_EXP_W-1:0] filter_exponent;
   logic               sample_tick;

   // Compensation
   logic [DATA_W-1:0]  vel_abs;
   logic [SCALE_W-1:0] gamma_d;
   logic [SCALE_W-1:0] gamma_q;
   logic [ANGLE_W-1:0] commutation_q;
   logic               emf_en;

   assign reg_idx   = address[ADDR_W-1:2];
   assign aligned   = (address[1:0] == 2'b00);
   // One wait cycle: the request is seen, then answered on the next edge
   assign wr_commit = write && !waitrequest_q && aligned;

   always_ff @(posedge clk) begin
      if (rst) begin
         waitrequest_q <= 1'b1;
      end else begin
         waitrequest_q <= !((read || write) && waitrequest_q);
      end
   end

   always_comb begin
      read_val = '0;
      if (aligned) begin
         case (reg_idx)
            IDX_CURRENT_CONTROL: read_val = current_control_q;
            IDX_CURRENT_LIMITS:  read_val = closed_loop_current_limits_q;
            IDX_ENCODER_INPUT:   read_val = encoder_input_settings_q;
            IDX_UP_DELAY:        read_val = scale_up_step_delay_q;
            IDX_DOWN_DELAY:      read_val = scale_down_step_delay_q;
            IDX_MAX_ANGLE:       read_val = DATA_W'(max_compensation_angle_q);
            IDX_DEVIATION_LIMIT: read_val = DATA_W'(full_scale_deviation_limit_q);
            IDX_MIN_VELOCITY:    read_val = compensation_min_velocity_q;
            IDX_VELOCITY_SPAN:   read_val = compensation_velocity_span_q;
            IDX_FILTER_CONFIG:   read_val = velocity_filter_config_q;
            IDX_MEASURED_VEL:    read_val = measured_encoder_velocity;
            IDX_FILTERED_VEL:    read_val = filtered_encoder_velocity_q;
            default:             read_val = '0;
         endcase
      end
   end

   // Captured on the first request cycle so data stands through the answer
   always_ff @(posedge clk) begin
      if (rst) begin
         readdata_q <= REG_RST;
      end else if (read && waitrequest_q) begin
         readdata_q <= read_val;
      end
   end

   // Read-only and unmapped words ignore writes
   always_ff @(posedge clk) begin
      if (rst) begin
         current_control_q            <= REG_RST;
         closed_loop_current_limits_q <= REG_RST;
         encoder_input_settings_q     <= REG_RST;
         scale_up_step_delay_q        <= REG_RST;
         scale_down_step_delay_q      <= REG_RST;
         max_compensation_angle_q     <= MAX_ANGLE_RST;
         full_scale_deviation_limit_q <= '0;
         compensation_min_velocity_q  <= REG_RST;
         compensation_velocity_span_q <= REG_RST;
         velocity_filter_config_q     <= REG_RST;
      end else if (wr_commit) begin
         case (reg_idx)
            IDX_CURRENT_CONTROL: current_control_q <=
               be_merge(current_control_q, writedata, byteenable);
            IDX_CURRENT_LIMITS: closed_loop_current_limits_q <=
               be_merge(closed_loop_current_limits_q, writedata, byteenable);
            IDX_ENCODER_INPUT: encoder_input_settings_q <=
               be_merge(encoder_input_settings_q, writedata, byteenable);
            IDX_UP_DELAY: scale_up_step_delay_q <=
               be_merge(scale_up_step_delay_q, writedata, byteenable);
            IDX_DOWN_DELAY: scale_down_step_delay_q <=
               be_merge(scale_down_step_delay_q, writedata, byteenable);
            IDX_MAX_ANGLE: max_compensation_angle_q <= SCALE_W'(
               be_merge(DATA_W'(max_compensation_angle_q), writedata, byteenable));
            IDX_DEVIATION_LIMIT: full_scale_deviation_limit_q <= LIMIT_W'(
               be_merge(DATA_W'(full_scale_deviation_limit_q), writedata, byteenable));
            IDX_MIN_VELOCITY: compensation_min_velocity_q <=
               be_merge(compensation_min_velocity_q, writedata, byteenable);
            IDX_VELOCITY_SPAN: compensation_velocity_span_q <=
               be_merge(compensation_velocity_span_q, writedata, byteenable);
            IDX_FILTER_CONFIG: velocity_filter_config_q <=
               be_merge(velocity_filter_config_q, writedata, byteenable);
            default: ;
         endcase
      end
   end

   // Current scaling
   assign cl_en   = current_control_q[CC_CL_SCALE_EN];
   assign dev_abs = abs_val(position_deviation);

   lin_interp u_scale_map (
      .x    ({1'b0, dev_abs}),
      .x_lo (INTERP_W'(closed_loop_current_limits_q[LIM_START_LSB +: SCALE_W])),
      .x_hi (INTERP_W'(full_scale_deviation_limit_q)),
      .y_lo (closed_loop_current_limits_q[LIM_MIN_LSB +: SCALE_W]),
      .y_hi (closed_loop_current_limits_q[LIM_MAX_LSB +: SCALE_W]),
      .y    (cl_target)
   );

   // Open-loop scale input has no effect once closed loop is on
   assign target_scale = cl_en ? cl_target : open_loop_scale;

   always_comb begin
      if (target_scale > applied_scale_q) begin
         ramp_state_d = RAMP_UP;
      end else if (target_scale < applied_scale_q) begin
         ramp_state_d = RAMP_DOWN;
      end else begin
         ramp_state_d = RAMP_HOLD;
      end
   end

   assign sel_delay    = (ramp_state_d == RAMP_UP) ? scale_up_step_delay_q
                                                   : scale_down_step_delay_q;
   // A change of direction restarts the step timer
   assign step_cnt_inc = (ramp_state_q == ramp_state_d) ? step_cnt_q + 32'h1 : 32'h1;

   always_ff @(posedge clk) begin
      if (rst) begin
         applied_scale_q <= '0;
         step_cnt_q      <= '0;
         ramp_state_q    <= RAMP_HOLD;
      end else begin
         ramp_state_q <= ramp_state_d;
         case (ramp_state_d)
            RAMP_UP: begin
               if (sel_delay == '0) begin
                  applied_scale_q <= target_scale;
                  step_cnt_q      <= '0;
               end else if (step_cnt_inc >= sel_delay) begin
                  applied_scale_q <= applied_scale_q + 8'h01;
                  step_cnt_q      <= '0;
               end else begin
                  step_cnt_q <= step_cnt_inc;
               end
            end
            RAMP_DOWN: begin
               if (sel_delay == '0) begin
                  applied_scale_q <= target_scale;
                  step_cnt_q      <= '0;
               end else if (step_cnt_inc >= sel_delay) begin
                  applied_scale_q <= applied_scale_q - 8'h01;
                  step_cnt_q      <= '0;
               end else begin
                  step_cnt_q <= step_cnt_inc;
               end
            end
            RAMP_HOLD: step_cnt_q <= '0;
            default:   step_cnt_q <= '0;
         endcase
      end
   end

   // Velocity filter; a period of zero or one samples every cycle
   assign sample_period   = encoder_input_settings_q[ENC_ABSOLUTE]
                          ? serial_request_period
                          : DATA_W'(velocity_filter_config_q[FLT_WAIT_LSB +: FLT_WAIT_W]);
   assign filter_exponent = velocity_filter_config_q[FLT_EXP_LSB +: FLT_EXP_W];
   assign wait_cnt_inc    = wait_cnt_q + 32'h1;
   assign sample_tick     = (wait_cnt_inc >= sample_period);

   always_ff @(posedge clk) begin
      if (rst) begin
         wait_cnt_q <= '0;
      end else begin
         wait_cnt_q <= sample_tick ? '0 : wait_cnt_inc;
      end
   end

   // Arithmetic shifts keep the mean's sign for reverse motion
   always_ff @(posedge clk) begin
      if (rst) begin
         filtered_encoder_velocity_q <= '0;
      end else if (sample_tick) begin
         filtered_encoder_velocity_q <= filtered_encoder_velocity_q
            - (filtered_encoder_velocity_q >>> filter_exponent)
            + (measured_encoder_velocity >>> filter_exponent);
      end
   end

   // Load-angle compensation
   assign emf_en  = encoder_input_settings_q[ENC_EMF_EN];
   assign vel_abs = abs_val(filtered_encoder_velocity_q);

   lin_interp u_angle_map (
      .x    ({1'b0, vel_abs}),
      .x_lo ({1'b0, compensation_min_velocity_q}),
      .x_hi ({1'b0, compensation_min_velocity_q} + {1'b0, compensation_velocity_span_q}),
      .y_lo ('0),
      .y_hi (max_compensation_angle_q),
      .y    (gamma_d)
   );

   // Sum wraps modulo one electrical period; bounded angles avoid reversal
   always_ff @(posedge clk) begin
      if (rst) begin
         gamma_q       <= '0;
         commutation_q <= '0;
      end else begin
         gamma_q <= emf_en ? gamma_d : '0;
         if (!emf_en) begin
            commutation_q <= commutation_angle;
         end else if (filtered_encoder_velocity_q[DATA_W-1]) begin
            commutation_q <= commutation_angle - ANGLE_W'(gamma_q);
         end else begin
            commutation_q <= commutation_angle + ANGLE_W'(gamma_q);
         end
      end
   end

   assign readdata        = readdata_q;
   assign waitrequest     = waitrequest_q;
   assign applied_scale   = applied_scale_q;
   assign comp_angle      = gamma_q;
   assign commutation_out = commutation_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_ro_read(logic [IDX_W-1:0] idx);
      read && waitrequest_q && aligned && (reg_idx == idx);
   endsequence

   sequence s_raise_now;
      (target_scale > applied_scale_q) && (scale_up_step_delay_q == '0);
   endsequence

   sequence s_lower_now;
      (target_scale < applied_scale_q) && (scale_down_step_delay_q == '0);
   endsequence

   AST_CL_OVERRIDE: assert property (cl_en |-> target_scale == cl_target)
      else $error("open-loop scale leaked into closed-loop target");
   AST_TARGET_MIN: assert property (
      dev_abs <= DATA_W'(closed_loop_current_limits_q[LIM_START_LSB +: SCALE_W])
      |-> cl_target == closed_loop_current_limits_q[LIM_MIN_LSB +: SCALE_W])
      else $error("target not at minimum inside start-up band");
   AST_TARGET_MAX: assert property (
      (dev_abs > DATA_W'(full_scale_deviation_limit_q)) &&
      (dev_abs > DATA_W'(closed_loop_current_limits_q[LIM_START_LSB +: SCALE_W]))
      |-> cl_target == closed_loop_current_limits_q[LIM_MAX_LSB +: SCALE_W])
      else $error("target not at maximum beyond deviation limit");
   AST_UP_STEP: assert property (
      (target_scale > applied_scale_q) && (scale_up_step_delay_q != '0)
      |=> (applied_scale_q == $past(applied_scale_q)) ||
          (applied_scale_q == SCALE_W'($past(applied_scale_q) + 8'h01)))
      else $error("applied scale rose by more than one step");
   AST_UP_NOW: assert property (
      s_raise_now |=> applied_scale_q == $past(target_scale))
      else $error("zero up-delay did not apply target at once");
   AST_DN_STEP: assert property (
      (target_scale < applied_scale_q) && (scale_down_step_delay_q == 32'h1)
      ##1 (target_scale < applied_scale_q)
      |-> applied_scale_q == SCALE_W'($past(applied_scale_q) - 8'h01))
      else $error("applied scale missed its one-cycle down step");
   AST_DN_NOW: assert property (
      s_lower_now |=> applied_scale_q == $past(target_scale))
      else $error("zero down-delay did not apply target at once");
   AST_COMP_ADD: assert property (
      emf_en && !filtered_encoder_velocity_q[DATA_W-1] |=> commutation_q ==
      ANGLE_W'($past(commutation_angle) + ANGLE_W'($past(gamma_q))))
      else $error("compensation angle not added in forward motion");
   AST_GAMMA_ZERO: assert property (
      emf_en && (vel_abs <= compensation_min_velocity_q) |=> gamma_q == '0)
      else $error("compensation angle nonzero below minimum velocity");
   AST_ANGLE_RST: assert property (
      $fell(rst) |-> max_compensation_angle_q == MAX_ANGLE_RST)
      else $error("maximum angle not at reset value");
   AST_RD_MEASURED: assert property (
      s_ro_read(IDX_MEASURED_VEL) ##1 !waitrequest_q
      |-> readdata_q == $past(measured_encoder_velocity))
      else $error("measured velocity read mismatch");
   AST_RD_FILTERED: assert property (
      s_ro_read(IDX_FILTERED_VEL) ##1 !waitrequest_q
      |-> readdata_q == $past(filtered_encoder_velocity_q))
      else $error("filtered velocity read mismatch");
   AST_WAIT_SRC: assert property (
      !encoder_input_settings_q[ENC_ABSOLUTE] |->
      sample_period == DATA_W'(velocity_filter_config_q[FLT_WAIT_LSB +: FLT_WAIT_W]))
      else $error("filter period not taken from wait field");
   AST_ABS_PERIOD: assert property (
      encoder_input_settings_q[ENC_ABSOLUTE] |-> sample_period == serial_request_period)
      else $error("absolute encoder period not used");
   AST_FILTER_UPD: assert property (sample_tick |=> filtered_encoder_velocity_q ==
      $past(filtered_encoder_velocity_q) - ($past(filtered_encoder_velocity_q) >>>
      $past(filter_exponent)) + ($past(measured_encoder_velocity) >>> $past(filter_exponent)))
      else $error("filter update mismatch");

endmodule

// ---- closed_loop_current_and_load_angle_tb.sv ----
// Self-checking bench for the closed-loop scaling and load-angle block.
// Assumes cl_pkg and enc_model are compiled first.
`timescale 1ns/10ps
module closed_loop_current_and_load_angle_tb;
   import cl_pkg::*;
   logic               clk, rst, read, write, waitrequest;
   logic [8:0]         address;
   logic [31:0]        writedata, readdata, rdat;
   logic signed [31:0] dev_set, vel_set, dev, vel;
   logic [7:0]         applied_scale, comp_angle;
   logic [9:0]         angle, commutation_out;
   int                 err_count, total_checks, cyc;
   logic signed [31:0] dv[5] = '{-40, 100, 8, 72, -73};
   logic [7:0]         ds[5] = '{8'h30, 8'h50, 8'h10, 8'h50, 8'h50};
   logic signed [31:0] vv[4] = '{1000, -1000, 50, 200};
   logic [7:0]         ga[4] = '{8'h80, 8'h80, 8'h00, 8'h40};
   logic [9:0]         co[4] = '{10'h180, 10'h080, 10'h100, 10'h140};
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   enc_model i_enc_model (.clk(clk), .dev_set(dev_set), .vel_set(vel_set), .dev(dev),
                          .vel(vel), .angle(angle));
   closed_loop_current_and_load_angle i_closed_loop_current_and_load_angle (
      .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .byteenable(4'hF), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .position_deviation(dev),
      .measured_encoder_velocity(vel), .serial_request_period(32'h0000_0002),
      .open_loop_scale(8'h77), .commutation_angle(angle),
      .commutation_out(commutation_out), .applied_scale(applied_scale),
      .comp_angle(comp_angle));
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [6:0] idx, input logic w, input logic [31:0] d);
      address <= {idx, 2'b00};
      writedata <= d;
      write <= w;
      read <= ~w;
      do @(posedge clk); while (waitrequest !== 1'b0);
      rdat = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [6:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 32'h0);
      chk(rdat, exp);
   endtask
   // Cycles between two consecutive steps of the applied scale
   task automatic gap(input int n);
      logic [7:0] a;
      int c;
      @(negedge clk);
      a = applied_scale;
      while (applied_scale === a) @(negedge clk);
      a = applied_scale;
      c = 0;
      while (applied_scale === a) begin
         @(negedge clk);
         c++;
      end
      chk(c, n);
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         err_count++;
         $display("ERROR %0t: timeout", $time);
         print_verdict();
      end
   end
   initial begin
      rst = 1'b1; read = 1'b0; write = 1'b0; address = 9'h0; writedata = 32'h0;
      dev_set = 32'sh0; vel_set = 32'sh50;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdchk(IDX_MAX_ANGLE, 32'h0000_00FF);
      rdchk(7'h7F, 32'h0);
      bus(IDX_MEASURED_VEL, 1'b1, 32'h0000_1234);
      rdchk(IDX_MEASURED_VEL, 32'h0000_0050);
      chk(applied_scale, 8'h77);
      bus(IDX_CURRENT_LIMITS, 1'b1, 32'h0008_5010);
      bus(IDX_DEVIATION_LIMIT, 1'b1, 32'h0000_0048);
      bus(IDX_CURRENT_CONTROL, 1'b1, 32'h1);
      repeat (3) @(posedge clk);
      chk(applied_scale, 8'h10);
      for (int i = 0; i < 5; i++) begin
         dev_set <= dv[i];
         repeat (4) @(posedge clk);
         chk(applied_scale, ds[i]);
      end
      bus(IDX_UP_DELAY, 1'b1, 32'h4);
      bus(IDX_DOWN_DELAY, 1'b1, 32'h3);
      dev_set <= 32'sh0;
      gap(3);
      dev_set <= 32'sh64;
      gap(4);
      bus(IDX_DOWN_DELAY, 1'b1, 32'h1);
      dev_set <= 32'sh0;
      gap(1);
      // Exponent 1 with an odd sample settles one below it, which a bare copy would miss
      bus(IDX_FILTER_CONFIG, 1'b1, 32'h0000_0128);
      vel_set <= 32'sh0A1;
      repeat (400) @(posedge clk);
      rdchk(IDX_FILTERED_VEL, 32'h0000_00A0);
      bus(IDX_FILTER_CONFIG, 1'b1, 32'h0000_0028);
      bus(IDX_MAX_ANGLE, 1'b1, 32'h80);
      bus(IDX_MIN_VELOCITY, 1'b1, 32'd100);
      bus(IDX_VELOCITY_SPAN, 1'b1, 32'd200);
      bus(IDX_ENCODER_INPUT, 1'b1, 32'h3);
      for (int i = 0; i < 4; i++) begin
         vel_set <= vv[i];
         repeat (12) @(posedge clk);
         chk(comp_angle, ga[i]);
         chk(commutation_out, co[i]);
      end
      print_verdict();
   end
endmodule

// ---- enc_model.sv ----
// Stand-in for the encoder unit and the commutation source.
// Assumes the bench sets deviation and velocity between clock edges.
`timescale 1ns/10ps
module enc_model (
   // Clock
   input  wire logic               clk,
   // Values requested by the bench
   input  wire logic signed [31:0] dev_set,
   input  wire logic signed [31:0] vel_set,
   // Outputs toward the block
   output logic signed      [31:0] dev,
   output logic signed      [31:0] vel,
   output logic             [9:0]  angle
);
   // Registered like the real unit, so values move only at edges
   always_ff @(posedge clk) begin
      dev <= dev_set;
      vel <= vel_set;
   end
   assign angle = 10'h100;
endmodule

// ---- lin_interp.sv ----
// Piecewise-linear map of an unsigned operand onto an 8-bit output range.
// Assumes breakpoints come straight from registers; purely combinational.
`timescale 1ns/10ps
module lin_interp (
   // Operand and breakpoints
   input  wire logic [cl_pkg::INTERP_W-1:0] x,
   input  wire logic [cl_pkg::INTERP_W-1:0] x_lo,
   input  wire logic [cl_pkg::INTERP_W-1:0] x_hi,
   // Output range
   input  wire logic [cl_pkg::SCALE_W-1:0]  y_lo,
   input  wire logic [cl_pkg::SCALE_W-1:0]  y_hi,
   output logic      [cl_pkg::SCALE_W-1:0]  y
);
   import cl_pkg::*;

   logic [INTERP_W-1:0]         span;
   logic [INTERP_W-1:0]         offs;
   logic [SCALE_W-1:0]          rise;
   logic [INTERP_W+SCALE_W-1:0] prod;
   logic [INTERP_W+SCALE_W-1:0] quo;

   // Truncating division keeps the result at or below y_hi
   always_comb begin
      span = x_hi - x_lo;
      offs = x - x_lo;
      rise = (y_hi > y_lo) ? SCALE_W'(y_hi - y_lo) : '0;
      prod = {{SCALE_W{1'b0}}, offs} * {{INTERP_W{1'b0}}, rise};
      quo  = (span == '0) ? '0 : prod / {{SCALE_W{1'b0}}, span};
      if (x <= x_lo) begin
         y = y_lo;
      end else if (x >= x_hi) begin
         y = y_hi;
      end else begin
         y = SCALE_W'(y_lo + quo[SCALE_W-1:0]);
      end
   end

endmodule
